// File: hw/sbl_defines.svh
// How it works
// - Latch boot, user and operating mode from pins
// - Boot link is one asynchronous serial channel
// - Boot starts loader, measures low, sets divisor
// - Measured low spans nine bit times
// - Send one zero byte when aligned
// - On 0x55 reply 0xaa, enter loader proper
// - Erase all flash unless already blank
// - Erase failure sends 0xff and halts loader
// - Send 0xaa, then length high, low, data
// - Echo every length and program byte
// - Store into 0xc00 window, base by mode
// - Loader work area is never written
// - Jump to window base after last byte
// - Alignment guaranteed only in listed clock ranges
// - Wait about 100 states before measuring
// - Before jump: serial off, divisor kept, pin high
// - Watchdog reset restarts loader, keeps latched mode
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and encodings
// ----------------------------------------------------------------
`define SBL_ADDR_W        24
`define SBL_MODE5         3'h5
`define SBL_MODE6         3'h6
`define SBL_MODE7         3'h7
`define SBL_BYTE_ALIGNED  8'h00
`define SBL_BYTE_SYNC     8'h55
`define SBL_BYTE_ACK      8'haa
`define SBL_BYTE_ERASE_ERR 8'hff

// ----------------------------------------------------------------
// RAM map
// ----------------------------------------------------------------
`define SBL_WIN_BASE_57   24'h0ff300
`define SBL_WIN_BASE_6    24'hfff300
`define SBL_WIN_SIZE      16'h0c00
`define SBL_RSV_BASE_57   24'h0fef10
`define SBL_RSV_BASE_6    24'hffef10
`define SBL_RSV_SIZE      24'h0003f0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBL_LOW_BITS      9
// One state is one system clock cycle
`define SBL_SETTLE_STATES 100
`define SBL_SETTLE_CYC    (`SBL_SETTLE_STATES * 1)
// Cycle at which the synchronised mode pins are valid
`define SBL_LATCH_CYC     2

`endif

// File: hw/sbl_pkg.sv
`include "sbl_defines.svh"

package sbl_pkg;

  // Gray codes along the normal path; error states off the path
  typedef enum logic [4:0] {
    SBL_SETTLE     = 5'h00,
    SBL_WAIT_HIGH  = 5'h01,
    SBL_WAIT_LOW   = 5'h03,
    SBL_MEASURE    = 5'h02,
    SBL_DIVIDE     = 5'h06,
    SBL_SEND_ALIGN = 5'h07,
    SBL_WAIT_SYNC  = 5'h05,
    SBL_SEND_ACK1  = 5'h04,
    SBL_CHECK      = 5'h0c,
    SBL_ERASE      = 5'h0d,
    SBL_SEND_ACK2  = 5'h0f,
    SBL_LEN_HI     = 5'h0e,
    SBL_LEN_LO     = 5'h0a,
    SBL_DATA       = 5'h0b,
    SBL_JUMP       = 5'h09,
    SBL_RUN        = 5'h08,
    SBL_SEND_ERR   = 5'h18,
    SBL_HALT       = 5'h19
  } sbl_state_e;

  typedef struct packed {
    logic       boot;
    logic       user;
    logic [2:0] op;
  } sbl_mode_s;

  typedef struct packed {
    logic                   we;
    logic [`SBL_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } sbl_ram_wr_s;

endpackage : sbl_pkg

// File: hw/sbl_uart_rx.sv
`timescale 1ns/10ps

module sbl_uart_rx #(
  parameter int DIV_W = 24
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             en,
  input  wire logic [DIV_W-1:0] bit_cycles,
  input  wire logic             rxd,
  output logic                  valid,
  output logic [7:0]            data
);

  logic             busy_q, busy_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [7:0]       sh_q, sh_d;
  logic             valid_q, valid_d;

  always_comb
  begin
    busy_d  = busy_q;
    cnt_d   = cnt_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    valid_d = 1'b0;
    if (!busy_q)
    begin
      // Sample at mid bit: first wait half a bit
      if (en && !rxd)
      begin
        busy_d = 1'b1;
        cnt_d  = bit_cycles >> 1;
        bit_d  = 4'h0;
      end
    end
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
    else
    begin
      cnt_d = bit_cycles - 1'b1;
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h0)
        busy_d = !rxd;
      else if (bit_q == 4'h9)
      begin
        busy_d  = 1'b0;
        valid_d = rxd;
      end
      else
        sh_d = {rxd, sh_q[7:1]};
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q  <= 1'b0;
      cnt_q   <= '0;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      valid_q <= 1'b0;
    end
    else
    begin
      busy_q  <= busy_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      valid_q <= valid_d;
    end
  end

  assign valid = valid_q;
  assign data  = sh_q;

endmodule : sbl_uart_rx

// File: hw/sbl_uart_tx.sv
`timescale 1ns/10ps

module sbl_uart_tx #(
  parameter int DIV_W = 24
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             en,
  input  wire logic [DIV_W-1:0] bit_cycles,
  input  wire logic             valid,
  input  wire logic [7:0]       data,
  output logic                  ready,
  output logic                  txd
);

  logic             busy_q, busy_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [9:0]       sh_q, sh_d;
  logic             txd_q, txd_d;

  // A frame in flight always completes, even if disabled meanwhile
  always_comb
  begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    txd_d  = txd_q;
    if (!busy_q)
    begin
      txd_d = 1'b1;
      if (en && valid)
      begin
        busy_d = 1'b1;
        sh_d   = {1'b1, data, 1'b0};
        cnt_d  = '0;
        bit_d  = 4'h0;
      end
    end
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
    else if (bit_q == 4'ha)
    begin
      busy_d = 1'b0;
      txd_d  = 1'b1;
    end
    else
    begin
      txd_d = sh_q[0];
      sh_d  = {1'b1, sh_q[9:1]};
      bit_d = bit_q + 4'h1;
      cnt_d = bit_cycles - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      bit_q  <= 4'h0;
      sh_q   <= 10'h3ff;
      txd_q  <= 1'b1;
    end
    else
    begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      txd_q  <= txd_d;
    end
  end

  assign ready = en && !busy_q;
  assign txd   = txd_q;

endmodule : sbl_uart_tx

// File: hw/sbl_top.sv
`timescale 1ns/10ps
`include "sbl_defines.svh"

module sbl_top #(
  parameter int DIV_W = 24
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      program_voltage_pin_hv,
  input  wire logic                      mode_pin_high_hv,
  input  wire logic                      mode_pin_high,
  input  wire logic                      mode_pin_mid,
  input  wire logic                      mode_pin_low,
  input  wire logic                      rxd,
  input  wire logic                      wdt_reset,
  input  wire logic                      flash_blank,
  input  wire logic                      erase_done,
  input  wire logic                      erase_fail,
  output logic                           boot_mode,
  output logic                           user_prog_mode,
  output logic [2:0]                     op_mode,
  output logic [DIV_W-1:0]               baud_divisor_register,
  output logic                           receiver_enable_bit,
  output logic                           transmitter_enable_bit,
  output logic                           txd,
  output logic                           txd_oe,
  output sbl_pkg::sbl_ram_wr_s           ram_wr,
  output logic                           erase_req,
  output logic                           jump,
  output logic [`SBL_ADDR_W-1:0]         jump_addr,
  output logic                           halted
);
  import sbl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic       rxd_s;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_q <= 6'h01;
      pin_sync_q <= 6'h01;
    end
    else
    begin
      pin_meta_q <= {mode_pin_low, mode_pin_mid, mode_pin_high,
                     mode_pin_high_hv, program_voltage_pin_hv, rxd};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign rxd_s = pin_sync_q[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sbl_state_e             state_q, state_d;
  sbl_mode_s              mode_q, mode_d;
  logic                   latched_q, latched_d;
  logic [DIV_W-1:0]       cnt_q, cnt_d;
  logic [DIV_W-1:0]       quot_q, quot_d;
  logic [DIV_W-1:0]       div_q, div_d;
  logic [15:0]            len_q, len_d;
  logic [15:0]            count_q, count_d;
  logic [7:0]             echo_q, echo_d;
  logic                   echo_pend_q, echo_pend_d;
  sbl_ram_wr_s            ram_q, ram_d;
  logic                   erase_q, erase_d;
  logic                   rx_en_q, rx_en_d;
  logic                   tx_en_q, tx_en_d;
  logic                   oe_q, oe_d;
  logic                   jump_q, jump_d;
  logic [`SBL_ADDR_W-1:0] jaddr_q, jaddr_d;
  logic                   halt_q, halt_d;

  logic                   rx_valid;
  logic [7:0]             rx_data;
  logic                   tx_valid;
  logic [7:0]             tx_data;
  logic                   tx_ready;
  logic                   tx_line;
  logic                   echo_state;
  logic [`SBL_ADDR_W-1:0] win_base;
  logic [2:0]             pin_op;

  // Ordered high, mid, low so the two low pins form the mode number
  assign pin_op   = {pin_sync_q[3], pin_sync_q[4], pin_sync_q[5]};
  assign win_base = (mode_q.op == `SBL_MODE6) ? `SBL_WIN_BASE_6
                                              : `SBL_WIN_BASE_57;
  assign echo_state = (state_q == SBL_LEN_HI) || (state_q == SBL_LEN_LO) ||
                      (state_q == SBL_DATA)   || (state_q == SBL_JUMP);

  // Fixed replies take the transmitter first; echoes fill the rest
  always_comb
  begin
    tx_valid = 1'b0;
    tx_data  = echo_q;
    case (state_q)
      SBL_SEND_ALIGN:
      begin
        tx_valid = 1'b1;
        tx_data  = `SBL_BYTE_ALIGNED;
      end
      SBL_SEND_ACK1, SBL_SEND_ACK2:
      begin
        tx_valid = 1'b1;
        tx_data  = `SBL_BYTE_ACK;
      end
      SBL_SEND_ERR:
      begin
        tx_valid = 1'b1;
        tx_data  = `SBL_BYTE_ERASE_ERR;
      end
      default:
        tx_valid = echo_state && echo_pend_q;
    endcase
  end

  always_comb
  begin
    state_d     = state_q;
    mode_d      = mode_q;
    latched_d   = latched_q;
    cnt_d       = cnt_q;
    quot_d      = quot_q;
    div_d       = div_q;
    len_d       = len_q;
    count_d     = count_q;
    echo_d      = echo_q;
    echo_pend_d = echo_pend_q;
    ram_d       = ram_q;
    ram_d.we    = 1'b0;
    erase_d     = erase_q;
    rx_en_d     = rx_en_q;
    tx_en_d     = tx_en_q;
    oe_d        = oe_q;
    jump_d      = 1'b0;
    jaddr_d     = jaddr_q;
    halt_d      = halt_q;

    // Clear first so that a new byte arriving in the same cycle wins
    if (echo_state && tx_valid && tx_ready)
      echo_pend_d = 1'b0;
    if (echo_state && state_q != SBL_JUMP && rx_valid)
    begin
      echo_pend_d = 1'b1;
      echo_d      = rx_data;
    end

    case (state_q)
      SBL_SETTLE:
      begin
        cnt_d = cnt_q + 1'b1;
        // Mode is caught once after power-on reset, not on a restart
        if (!latched_q && cnt_q == DIV_W'(`SBL_LATCH_CYC))
        begin
          latched_d   = 1'b1;
          mode_d.boot = pin_sync_q[1] && pin_sync_q[2] &&
                        (pin_op[1:0] != 2'h0);
          mode_d.user = pin_sync_q[1] && !pin_sync_q[2] && pin_sync_q[3] &&
                        (pin_op[1:0] != 2'h0);
          mode_d.op   = (pin_op[1:0] != 2'h0) ? {1'b1, pin_op[1:0]} : 3'h0;
        end
        if (cnt_q == DIV_W'(`SBL_SETTLE_CYC - 1))
        begin
          cnt_d   = '0;
          state_d = (mode_q.boot && mode_q.op != 3'h0) ? SBL_WAIT_HIGH
                                                       : SBL_RUN;
        end
      end
      SBL_WAIT_HIGH:
        if (rxd_s)
          state_d = SBL_WAIT_LOW;
      SBL_WAIT_LOW:
        if (!rxd_s)
        begin
          state_d = SBL_MEASURE;
          cnt_d   = DIV_W'(1);
        end
      SBL_MEASURE:
        if (!rxd_s)
        begin
          // Saturate: wide enough for 2400 bps at this clock
          if (cnt_q != '1)
            cnt_d = cnt_q + 1'b1;
        end
        else
        begin
          state_d = SBL_DIVIDE;
          quot_d  = '0;
        end
      SBL_DIVIDE:
        // Serial division keeps area small; costs one cycle per quotient step, about one bit time
        if (cnt_q >= DIV_W'(`SBL_LOW_BITS))
        begin
          cnt_d  = cnt_q - DIV_W'(`SBL_LOW_BITS);
          quot_d = quot_q + 1'b1;
        end
        else
        begin
          div_d   = (quot_q == '0) ? DIV_W'(1) : quot_q;
          rx_en_d = 1'b1;
          tx_en_d = 1'b1;
          oe_d    = 1'b1;
          state_d = SBL_SEND_ALIGN;
        end
      SBL_SEND_ALIGN:
        if (tx_ready)
          state_d = SBL_WAIT_SYNC;
      SBL_WAIT_SYNC:
        // Stray zero bytes still in flight are dropped here
        if (rx_valid && rx_data == `SBL_BYTE_SYNC)
          state_d = SBL_SEND_ACK1;
      SBL_SEND_ACK1:
        if (tx_ready)
          state_d = SBL_CHECK;
      SBL_CHECK:
        if (flash_blank)
          state_d = SBL_SEND_ACK2;
        else
        begin
          erase_d = 1'b1;
          state_d = SBL_ERASE;
        end
      SBL_ERASE:
        if (erase_fail)
        begin
          erase_d = 1'b0;
          state_d = SBL_SEND_ERR;
        end
        else if (erase_done)
        begin
          erase_d = 1'b0;
          state_d = SBL_SEND_ACK2;
        end
      SBL_SEND_ERR:
        if (tx_ready)
        begin
          rx_en_d = 1'b0;
          halt_d  = 1'b1;
          state_d = SBL_HALT;
        end
      SBL_HALT:
        state_d = SBL_HALT;
      SBL_SEND_ACK2:
        if (tx_ready)
          state_d = SBL_LEN_HI;
      SBL_LEN_HI:
        if (rx_valid)
        begin
          len_d[15:8] = rx_data;
          state_d     = SBL_LEN_LO;
        end
      SBL_LEN_LO:
        if (rx_valid)
        begin
          len_d[7:0] = rx_data;
          count_d    = 16'h0000;
          state_d    = ({len_q[15:8], rx_data} == 16'h0000) ? SBL_JUMP
                                                            : SBL_DATA;
        end
      SBL_DATA:
        if (rx_valid)
        begin
          // Writes stop at the window end, so nothing past the window is written
          if (count_q < `SBL_WIN_SIZE)
          begin
            ram_d.we   = 1'b1;
            ram_d.addr = win_base + {8'h00, count_q};
            ram_d.data = rx_data;
          end
          count_d = count_q + 16'h0001;
          if (count_q + 16'h0001 == len_q)
            state_d = SBL_JUMP;
        end
      SBL_JUMP:
        // Last echo must leave the pin before the serial unit shuts off
        if (!echo_pend_q && tx_ready)
        begin
          rx_en_d = 1'b0;
          tx_en_d = 1'b0;
          oe_d    = 1'b1;
          jump_d  = 1'b1;
          jaddr_d = win_base;
          state_d = SBL_RUN;
        end
      SBL_RUN:
        state_d = SBL_RUN;
      default:
        state_d = SBL_SETTLE;
    endcase

    if (wdt_reset && mode_q.boot)
    begin
      state_d     = SBL_SETTLE;
      cnt_d       = '0;
      rx_en_d     = 1'b0;
      tx_en_d     = 1'b0;
      erase_d     = 1'b0;
      echo_pend_d = 1'b0;
      halt_d      = 1'b0;
      ram_d.we    = 1'b0;
      jump_d      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q     <= SBL_SETTLE;
      mode_q      <= '0;
      latched_q   <= 1'b0;
      cnt_q       <= '0;
      quot_q      <= '0;
      div_q       <= DIV_W'(1);
      len_q       <= 16'h0000;
      count_q     <= 16'h0000;
      echo_q      <= 8'h00;
      echo_pend_q <= 1'b0;
      ram_q       <= '0;
      erase_q     <= 1'b0;
      rx_en_q     <= 1'b0;
      tx_en_q     <= 1'b0;
      oe_q        <= 1'b0;
      jump_q      <= 1'b0;
      jaddr_q     <= '0;
      halt_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      latched_q   <= latched_d;
      cnt_q       <= cnt_d;
      quot_q      <= quot_d;
      div_q       <= div_d;
      len_q       <= len_d;
      count_q     <= count_d;
      echo_q      <= echo_d;
      echo_pend_q <= echo_pend_d;
      ram_q       <= ram_d;
      erase_q     <= erase_d;
      rx_en_q     <= rx_en_d;
      tx_en_q     <= tx_en_d;
      oe_q        <= oe_d;
      jump_q      <= jump_d;
      jaddr_q     <= jaddr_d;
      halt_q      <= halt_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial channel
  // ----------------------------------------------------------------
  sbl_uart_rx #(.DIV_W(DIV_W)) u_rx (
    .clk        (clk),
    .resetn     (resetn),
    .en         (rx_en_q),
    .bit_cycles (div_q),
    .rxd        (rxd_s),
    .valid      (rx_valid),
    .data       (rx_data)
  );

  sbl_uart_tx #(.DIV_W(DIV_W)) u_tx (
    .clk        (clk),
    .resetn     (resetn),
    .en         (tx_en_q),
    .bit_cycles (div_q),
    .valid      (tx_valid),
    .data       (tx_data),
    .ready      (tx_ready),
    .txd        (tx_line)
  );

  assign boot_mode              = mode_q.boot;
  assign user_prog_mode         = mode_q.user;
  assign op_mode                = mode_q.op;
  assign baud_divisor_register  = div_q;
  assign receiver_enable_bit    = rx_en_q;
  assign transmitter_enable_bit = tx_en_q;
  assign txd                    = tx_line;
  assign txd_oe                 = oe_q;
  assign ram_wr                 = ram_q;
  assign erase_req              = erase_q;
  assign jump                   = jump_q;
  assign jump_addr              = jaddr_q;
  assign halted                 = halt_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_boot_op;
    @(posedge clk) disable iff (!resetn)
    boot_mode && state_q != SBL_SETTLE |-> op_mode >= `SBL_MODE5;
  endproperty
  a_boot_op: assert property (p_boot_op)
    else $error("boot mode with invalid operating mode");

  property p_settle;
    @(posedge clk) disable iff (!resetn)
    state_q == SBL_WAIT_HIGH && $past(state_q) == SBL_SETTLE
      |-> $past(cnt_q) == DIV_W'(`SBL_SETTLE_CYC - 1);
  endproperty
  a_settle: assert property (p_settle)
    else $error("measurement began before settle time");

  property p_align;
    @(posedge clk) disable iff (!resetn)
    $rose(tx_en_q) |-> state_q == SBL_SEND_ALIGN && div_q != '0
      && tx_valid && tx_data == `SBL_BYTE_ALIGNED;
  endproperty
  a_align: assert property (p_align)
    else $error("alignment byte not offered after divisor set");

  property p_sync_ack;
    @(posedge clk) disable iff (!resetn)
    state_q == SBL_WAIT_SYNC && rx_valid && rx_data == `SBL_BYTE_SYNC
      && !wdt_reset |=> tx_valid && tx_data == `SBL_BYTE_ACK;
  endproperty
  a_sync_ack: assert property (p_sync_ack)
    else $error("sync byte not answered");

  property p_erase;
    @(posedge clk) disable iff (!resetn)
    state_q == SBL_CHECK && !flash_blank && !wdt_reset |=> erase_q;
  endproperty
  a_erase: assert property (p_erase)
    else $error("non-blank flash not erased");

  property p_halt;
    @(posedge clk) disable iff (!resetn)
    halt_q |-> !ram_q.we && !jump_q && !rx_en_q && !erase_q;
  endproperty
  a_halt: assert property (p_halt)
    else $error("loader active after erase error");

  property p_echo;
    @(posedge clk) disable iff (!resetn)
    state_q == SBL_DATA && rx_valid && !wdt_reset
      |=> echo_pend_q && echo_q == $past(rx_data);
  endproperty
  a_echo: assert property (p_echo)
    else $error("received byte not queued for echo");

  property p_window;
    @(posedge clk) disable iff (!resetn)
    ram_q.we |-> ram_q.addr >= win_base
      && ram_q.addr < win_base + {8'h00, `SBL_WIN_SIZE};
  endproperty
  a_window: assert property (p_window)
    else $error("write outside download window");

  property p_jump;
    @(posedge clk) disable iff (!resetn)
    jump_q |-> jaddr_q == win_base && !rx_en_q && !tx_en_q && oe_q
      && count_q == len_q;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump state wrong");

endmodule : sbl_top

// File: tb/sbl_host.sv
`timescale 1ns/10ps

module sbl_host #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] rx_q[$];
  logic [7:0] b;

  initial line_out = 1'b1;

  // ----------------------------------------
  // Host side of the serial link
  // ----------------------------------------
  // 8N1, LSB first; one spare idle bit so echoes never pile up
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      line_out <= (i < 10) ? f[i] : 1'b1;
      repeat (BIT - 1) @(posedge clk);
    end
  endtask : send

  // Stop bit is not judged: a bad frame shows up as a wrong byte
  initial forever
  begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk);
      b[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
    rx_q.push_back(b);
  end
endmodule : sbl_host

// File: tb/test_sbl_top.sv
`timescale 1ns/10ps

module test_sbl_top;
  import sbl_pkg::*;
  localparam int BIT = 16;
  logic clk = 1'b0, resetn = 1'b0, wdt = 1'b0, blank = 1'b1;
  logic vpp = 1'b0, hv = 1'b0, hi = 1'b0, mid = 1'b0, low = 1'b0;
  logic e_done = 1'b0, e_fail = 1'b0, jseen = 1'b0;
  logic boot, user, rx_en, tx_en, txd, txd_oe, erase_req, jump, halted;
  logic [2:0] op;
  logic [23:0] div, jaddr, jseen_addr;
  logic line_dev, line_host;
  sbl_ram_wr_s ram_wr;
  sbl_ram_wr_s wq[$];
  int mismatches = 0;
  int num_checks = 0;

  always #2 clk = ~clk;
  // Board pull-up keeps the line high while the device is not driving
  assign line_dev = txd_oe ? txd : 1'b1;

  sbl_host #(.BIT(BIT)) host (.clk(clk), .line_in(line_dev),
    .line_out(line_host));

  sbl_top dut (.clk(clk), .resetn(resetn), .program_voltage_pin_hv(vpp),
    .mode_pin_high_hv(hv), .mode_pin_high(hi), .mode_pin_mid(mid),
    .mode_pin_low(low), .rxd(line_host), .wdt_reset(wdt),
    .flash_blank(blank), .erase_done(e_done), .erase_fail(e_fail),
    .boot_mode(boot), .user_prog_mode(user), .op_mode(op),
    .baud_divisor_register(div), .receiver_enable_bit(rx_en),
    .transmitter_enable_bit(tx_en), .txd(txd), .txd_oe(txd_oe),
    .ram_wr(ram_wr), .erase_req(erase_req), .jump(jump),
    .jump_addr(jaddr), .halted(halted));

  // ----------------------------------------
  // Monitors and helpers
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (ram_wr.we === 1'b1) wq.push_back(ram_wr);
    if (jump === 1'b1)
    begin
      jseen = 1'b1;
      jseen_addr = jaddr;
    end
  end

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic get(input logic [7:0] exp);
    int n;
    n = 0;
    while (host.rx_q.size() == 0 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    chk("serial byte", (host.rx_q.size() > 0) ? host.rx_q.pop_front()
        : 8'hxx, exp);
  endtask : get

  task automatic rst(input logic [4:0] pins);
    @(posedge clk);
    {vpp, hv, hi, mid, low} <= pins;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (120) @(posedge clk);
  endtask : rst

  task automatic align();
    for (int i = 0; i < 20 && host.rx_q.size() == 0; i++)
      host.send(8'h00);
    get(8'h00);
    chk("divisor", div, BIT);
    repeat (2 * BIT) @(posedge clk);
    host.send(8'h55);
    get(8'haa);
  endtask : align

  task automatic erase(input logic fail);
    int n;
    n = 0;
    while (erase_req !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("erase request", erase_req, 1'b1);
    @(posedge clk);
    e_done <= ~fail;
    e_fail <= fail;
    @(posedge clk);
    e_done <= 1'b0;
    e_fail <= 1'b0;
  endtask : erase

  // Two-byte program, well under the window size
  task automatic download(input logic [23:0] base);
    logic [7:0] pl [4];
    pl = '{8'h00, 8'h02, 8'h3c, 8'hc3};
    get(8'haa);
    wq.delete();
    jseen = 1'b0;
    foreach (pl[i])
    begin
      host.send(pl[i]);
      get(pl[i]);
    end
    chk("writes", wq.size(), 2);
    for (int i = 0; i < 2; i++)
    begin
      chk("ram addr", wq[i].addr, base + i);
      chk("ram data", wq[i].data, pl[i + 2]);
    end
    // Jump follows only once the last echo's stop bit has left the pin
    repeat (2 * BIT) @(negedge clk);
    chk("jump", jseen, 1'b1);
    chk("jump addr", jseen_addr, base);
    chk("serial off", {rx_en, tx_en, txd_oe, txd}, 4'b0011);
    chk("divisor kept", div, BIT);
  endtask : download

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst(5'b11001);
    chk("mode", {boot, user, op}, 5'b10101);
    blank <= 1'b0;
    align();
    erase(1'b0);
    download(24'h0ff300);
    rst(5'b11010);
    align();
    erase(1'b1);
    get(8'hff);
    repeat (8) @(negedge clk);
    chk("halted", halted, 1'b1);
    @(posedge clk);
    {vpp, hv, hi, mid, low} <= 5'b00000;
    blank <= 1'b1;
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (120) @(posedge clk);
    chk("wdt restart", {halted, boot, op}, 5'b01110);
    align();
    download(24'hfff300);
    rst(5'b10111);
    chk("mode", {boot, user, op}, 5'b01111);
    results();
  end

  initial
  begin
    #400000;
    mismatches++;
    results();
  end
endmodule : test_sbl_top
